// ===== core/adc_ctrl.sv
// Converter control, prescaler, trigger logic and result registers
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module adc_ctrl
  import adc_ctrl_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rstn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger sources, codes 1 to 6
  input wire logic [6:1] trig_src,
  // Interrupt
  input wire logic global_irq_en,
  input wire logic irq_ack,
  output logic irq_req,
  // Converter core
  output logic core_power,
  output logic core_sample,
  output logic core_clk_tick,
  output logic [3:0] core_channel,
  output logic core_gain_20x,
  output logic core_diff,
  output logic core_init,
  input wire logic [9:0] core_code
);
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] insel_r, insel_nxt;
  logic [2:0] tsel_r, tsel_nxt;
  logic [3:0] chan_r, chan_nxt;
  logic [9:0] res_r, res_nxt;
  logic lock_r, lock_nxt;
  logic first_r, first_nxt;
  logic trig_d_r, trig_d_nxt;
  logic [6:0] div_r, div_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  conv_state_type state_r, state_nxt;
  logic wr;
  logic rd;
  logic tick;
  logic trig_now;
  logic start_req;
  logic done;
  logic mapped;
  logic [7:0] low_b, high_b;
  logic [6:0] div_mask;

  assign wr = psel && penable && pwrite && pstrb[0];
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = paddr == OFF_RESULT_LOW || paddr == OFF_RESULT_HIGH || paddr == OFF_CTRL_STATUS ||
                  paddr == OFF_INPUT_SELECT || paddr == OFF_CTRL_B;
  assign pslverr = psel && penable && !mapped;

  // Division mask, codes 0 and 1 both divide by two
  always_comb begin
    case (ctrl_r[2:0])
      3'd0, 3'd1: div_mask = 7'h01;
      3'd2: div_mask = 7'h03;
      3'd3: div_mask = 7'h07;
      3'd4: div_mask = 7'h0F;
      3'd5: div_mask = 7'h1F;
      3'd6: div_mask = 7'h3F;
      default: div_mask = 7'h7F;
    endcase
  end
  assign tick = ctrl_r[BIT_ENABLE] && ((div_r & div_mask) == div_mask);

  // Trigger selection; free running has no source of its own
  always_comb begin
    trig_d_nxt = (tsel_r == TRIG_FREE) ? 1'b0 : trig_src[tsel_r];
    if (tsel_r == 3'd7) begin
      trig_d_nxt = 1'b0;
    end
  end
  assign trig_now = trig_d_nxt && !trig_d_r;
  assign done = state_r == st_convert && tick && cnt_r == 5'd1;

  // Start requests: software write or trigger edge; free-running restart is handled at completion
  always_comb begin
    start_req = 1'b0;
    if (wr && paddr == OFF_CTRL_STATUS && pwdata[BIT_START]) begin
      start_req = 1'b1;
    end
    if (ctrl_r[BIT_AUTO] && trig_now) begin
      start_req = 1'b1;
    end
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    insel_nxt = insel_r;
    tsel_nxt = tsel_r;
    chan_nxt = chan_r;
    res_nxt = res_r;
    lock_nxt = lock_r;
    first_nxt = first_r;
    div_nxt = ctrl_r[BIT_ENABLE] ? div_r + 7'd1 : 7'd0;
    cnt_nxt = cnt_r;
    state_nxt = state_r;
    if (wr && paddr == OFF_INPUT_SELECT) begin
      insel_nxt = pwdata[7:0];
    end
    if (wr && paddr == OFF_CTRL_B) begin
      tsel_nxt = pwdata[2:0];
    end
    if (wr && paddr == OFF_CTRL_STATUS) begin
      ctrl_nxt[7] = pwdata[7];
      ctrl_nxt[5] = pwdata[5];
      ctrl_nxt[3:0] = pwdata[3:0];
      if (pwdata[BIT_FLAG]) begin
        ctrl_nxt[BIT_FLAG] = 1'b0;
      end
      if (pwdata[BIT_ENABLE] && !ctrl_r[BIT_ENABLE]) begin
        first_nxt = 1'b1;
      end
    end
    if (irq_ack) begin
      ctrl_nxt[BIT_FLAG] = 1'b0;
    end
    // Reading low locks, reading high releases
    if (rd && paddr == OFF_RESULT_LOW) begin
      lock_nxt = 1'b1;
    end
    if (rd && paddr == OFF_RESULT_HIGH) begin
      lock_nxt = 1'b0;
    end
    case (state_r)
      st_idle: begin
        chan_nxt = insel_nxt[3:0];
        if (start_req && ctrl_nxt[BIT_ENABLE]) begin
          state_nxt = st_convert;
          ctrl_nxt[BIT_START] = 1'b1;
          cnt_nxt = first_nxt ? FIRST_CYCLES : NORMAL_CYCLES;
        end
      end
      st_convert: begin
        if (tick) begin
          cnt_nxt = cnt_r - 5'd1;
        end
        if (done) begin
          first_nxt = 1'b0;
          if (!lock_nxt) begin
            res_nxt = core_code;
          end
          ctrl_nxt[BIT_FLAG] = 1'b1;
          chan_nxt = insel_nxt[3:0];
          if (ctrl_nxt[BIT_AUTO] && tsel_r == TRIG_FREE || start_req) begin
            cnt_nxt = NORMAL_CYCLES;
          end else begin
            state_nxt = st_idle;
            ctrl_nxt[BIT_START] = 1'b0;
          end
        end
      end
      default: state_nxt = st_idle;
    endcase
    if (!ctrl_nxt[BIT_ENABLE]) begin
      state_nxt = st_idle;
      ctrl_nxt[BIT_START] = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= RESET_BYTE;
      insel_r <= RESET_BYTE;
      tsel_r <= 3'h0;
      chan_r <= 4'h0;
      res_r <= 10'h000;
      lock_r <= 1'b0;
      first_r <= 1'b0;
      trig_d_r <= 1'b0;
      div_r <= 7'h00;
      cnt_r <= 5'h00;
      state_r <= st_idle;
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
      insel_r <= insel_nxt;
      tsel_r <= tsel_nxt;
      chan_r <= chan_nxt;
      res_r <= res_nxt;
      lock_r <= lock_nxt;
      first_r <= first_nxt;
      trig_d_r <= trig_d_nxt;
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      state_r <= state_nxt;
    end
  end

  // Layout follows left adjust at once, no conversion wait
  assign low_b = insel_r[BIT_LEFT_ADJ] ? {res_r[1:0], 6'h00} : res_r[7:0];
  assign high_b = insel_r[BIT_LEFT_ADJ] ? res_r[9:2] : {6'h00, res_r[9:8]};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      case (paddr)
        OFF_RESULT_LOW: prdata <= {24'h000000, low_b};
        OFF_RESULT_HIGH: prdata <= {24'h000000, high_b};
        OFF_CTRL_STATUS: prdata <= {24'h000000, ctrl_r};
        OFF_INPUT_SELECT: prdata <= {24'h000000, insel_r};
        OFF_CTRL_B: prdata <= {29'h0, tsel_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign irq_req = ctrl_r[BIT_FLAG] && ctrl_r[BIT_IRQ_EN] && global_irq_en;
  assign core_power = ctrl_r[BIT_ENABLE];
  assign core_sample = state_r == st_convert;
  assign core_clk_tick = tick && state_r == st_convert;
  assign core_channel = chan_r;
  assign core_diff = chan_r >= CH_DIFF_LO && chan_r <= CH_DIFF_HI;
  assign core_gain_20x = core_diff && chan_r[0];
  assign core_init = first_r && state_r == st_convert;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_flag_on_done;
    clk_en && done |=> ctrl_r[BIT_FLAG];
  endproperty
  a_flag_on_done: assert property (p_flag_on_done) else $error("flag not set on done");
  property p_irq;
    irq_req == (ctrl_r[BIT_FLAG] && ctrl_r[BIT_IRQ_EN] && global_irq_en);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_busy_start;
    state_r == st_convert |-> ctrl_r[BIT_START];
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("start bit low while busy");
  property p_off_abort;
    clk_en && !ctrl_nxt[BIT_ENABLE] |=> state_r == st_idle;
  endproperty
  a_off_abort: assert property (p_off_abort) else $error("conversion not aborted");
  property p_chan_hold;
    state_r == st_convert && !done && clk_en |=> $stable(chan_r);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel changed mid conversion");
  property p_lock;
    lock_r && clk_en && !(rd && paddr == OFF_RESULT_HIGH) |=> $stable(res_r);
  endproperty
  a_lock: assert property (p_lock) else $error("result updated while locked");
  property p_gain;
    core_gain_20x |-> core_diff && chan_r[0];
  endproperty
  a_gain: assert property (p_gain) else $error("gain select wrong");
  property p_first_len;
    clk_en && state_r == st_idle && state_nxt == st_convert && first_nxt |=> cnt_r == FIRST_CYCLES;
  endproperty
  a_first_len: assert property (p_first_len) else $error("first conversion length wrong");
  property p_left;
    insel_r[BIT_LEFT_ADJ] |-> high_b == res_r[9:2];
  endproperty
  a_left: assert property (p_left) else $error("left adjust layout wrong");
  c_done: cover property (done);
  c_lock: cover property (lock_r && done);
  c_trig: cover property (ctrl_r[BIT_AUTO] && trig_now);
  c_free: cover property (done && state_nxt == st_convert);
  c_first: cover property (core_init && done);
  // Sequencing checks; results and flags follow the counter and the bus

  property p_flag_clear;
    clk_en && irq_ack && !done |=> !ctrl_r[BIT_FLAG];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared by vector");

  property p_flag_keep;
    clk_en && !done && !irq_ack && !(wr && paddr == OFF_CTRL_STATUS && pwdata[BIT_FLAG]) |=>
      ctrl_r[BIT_FLAG] == $past(ctrl_r[BIT_FLAG]);
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag changed without cause");

  property p_zero_start;
    clk_en && state_r == st_idle && !start_req |=> state_r == st_idle && !ctrl_r[BIT_START];
  endproperty
  a_zero_start: assert property (p_zero_start) else $error("conversion began without request");

  property p_start_clear;
    clk_en && done && !ctrl_nxt[BIT_AUTO] && !start_req |=> !ctrl_r[BIT_START];
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit kept after completion");

  property p_sw_start;
    clk_en && state_r == st_idle && wr && paddr == OFF_CTRL_STATUS && pwdata[BIT_START] &&
      pwdata[BIT_ENABLE] |=> state_r == st_convert;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("start write ignored");

  property p_trig_start;
    clk_en && state_r == st_idle && ctrl_r[BIT_AUTO] && trig_now && ctrl_nxt[BIT_ENABLE] |=>
      state_r == st_convert;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger edge ignored");

  property p_free_run;
    clk_en && done && ctrl_nxt[BIT_AUTO] && tsel_r == TRIG_FREE && ctrl_nxt[BIT_ENABLE] |=>
      state_r == st_convert && cnt_r == NORMAL_CYCLES;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free running did not restart");

  property p_result;
    clk_en && done && !lock_nxt |=> res_r == $past(core_code) && ctrl_r[BIT_FLAG];
  endproperty
  a_result: assert property (p_result) else $error("result not taken on completion");

  property p_lock_set;
    clk_en && rd && paddr == OFF_RESULT_LOW |=> lock_r;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("low read did not lock");

  property p_right;
    !insel_r[BIT_LEFT_ADJ] |-> high_b == {6'h00, res_r[9:8]} && low_b == res_r[7:0];
  endproperty
  a_right: assert property (p_right) else $error("right adjust layout wrong");

  property p_left_low;
    insel_r[BIT_LEFT_ADJ] |-> low_b == {res_r[1:0], 6'h00};
  endproperty
  a_left_low: assert property (p_left_low) else $error("left adjust low byte wrong");

  property p_tick_off;
    !ctrl_r[BIT_ENABLE] |-> !tick;
  endproperty
  a_tick_off: assert property (p_tick_off) else $error("prescaler runs while off");

  property p_idle_no_tick;
    state_r == st_idle |-> !core_clk_tick;
  endproperty
  a_idle_no_tick: assert property (p_idle_no_tick) else $error("core tick while idle");

  property p_later_len;
    clk_en && state_r == st_idle && state_nxt == st_convert && !first_nxt |=> cnt_r == NORMAL_CYCLES;
  endproperty
  a_later_len: assert property (p_later_len) else $error("later conversion length wrong");

  property p_trig_free;
    tsel_r == TRIG_FREE |-> !trig_d_nxt;
  endproperty
  a_trig_free: assert property (p_trig_free) else $error("free running made a trigger");

  property p_irq_off;
    !global_irq_en |-> !irq_req;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt while globally masked");
endmodule

// ===== core/adc_ctrl_pkg.sv
// Constants for the converter control and result register block
// Function
// - Left adjust reformats result immediately
// - Channel code routes single, differential, internal inputs
// - Differential even codes 1x, odd 20x
// - Channel change waits for conversion end
// - Enable powers converter, clearing aborts conversion
// - Start write begins conversion
// - First conversion 25 cycles, later 13
// - Start reads one while busy, zero-write ignored
// - Auto trigger starts on selected rising edge
// - Done flag set with result update
// - Interrupt when flag, enable, global enable
// - Flag clears on vector or one-write
// - Prescaler divides clock 2 up to 128
// - Right and left adjusted result layouts
// - Low byte read locks result until high
// - Trigger source select; free running no trigger
package adc_ctrl_pkg;
  localparam logic [11:0] OFF_RESULT_LOW = 12'h010;
  localparam logic [11:0] OFF_RESULT_HIGH = 12'h014;
  localparam logic [11:0] OFF_CTRL_STATUS = 12'h018;
  localparam logic [11:0] OFF_INPUT_SELECT = 12'h01C;
  localparam logic [11:0] OFF_CTRL_B = 12'h00C;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_START = 6;
  localparam int BIT_AUTO = 5;
  localparam int BIT_FLAG = 4;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_LEFT_ADJ = 5;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [4:0] FIRST_CYCLES = 5'd25;
  localparam logic [4:0] NORMAL_CYCLES = 5'd13;
  localparam logic [3:0] CH_DIFF_LO = 4'h4;
  localparam logic [3:0] CH_DIFF_HI = 4'hB;
  localparam logic [3:0] CH_UNUSED = 4'hE;
  localparam logic [2:0] TRIG_FREE = 3'h0;
  typedef enum logic [1:0] {st_idle, st_convert} conv_state_type;
endpackage

// ===== testbench/core_model.sv
// Behavioural converter core that returns a code set by the bench
`timescale 1ns/100ps
module core_model (
  // Core side
  input wire logic core_sample,
  input wire logic [9:0] val,
  output logic [9:0] core_code
);
  // Inverted code outside a conversion, so a stray sample is seen
  assign core_code = core_sample ? val : ~val;
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %0h want %0h", $time, a, e); end end
module tb;
  import adc_ctrl_pkg::*;
  logic mclk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, gie = 0, ack = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [6:1] trig = 0;
  logic pready, pslverr, irq, pwr, smp, tk, gn, df, ini, err;
  logic [3:0] ch;
  logic [9:0] val = 0, code;
  logic [7:0] rd;
  int n_fail = 0, check_count = 0, res = 0, lk = 0, s;
  integer seed = 32'hD5C1E420;
  adc_ctrl dut (.mclk(mclk), .rstn(rstn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trig_src(trig), .global_irq_en(gie), .irq_ack(ack),
    .irq_req(irq), .core_power(pwr), .core_sample(smp), .core_clk_tick(tk), .core_channel(ch),
    .core_gain_20x(gn), .core_diff(df), .core_init(ini), .core_code(code));
  core_model cm (.core_sample(smp), .val(val), .core_code(code));
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task conclude;
    $display("checks %0d fails %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      conclude;
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Counts converter ticks and their spacing; stop leaves at the last tick for back-to-back runs
  task automatic run(input int nt, input int dv, input bit stop);
    int t, c, f, l;
    t = 0;
    c = 0;
    f = 0;
    l = 0;
    while (c < 20000 && !(t > 0 && (smp === 1'b0 || (stop && t == nt)))) begin
      @(posedge mclk);
      c++;
      if (tk === 1'b1) begin
        t++;
        if (t == 1) f = c;
        l = c;
      end
    end
    `CHK(t, nt)
    `CHK(l - f, (nt - 1) * dv)
    if (lk == 0) res = val;
  endtask
  task automatic res_chk;
    logic [15:0] e;
    for (int l = 0; l < 2; l++) begin
      apb(1'b1, OFF_INPUT_SELECT, 8'(l << 5));
      e = l ? {res[9:0], 6'h00} : {6'h00, res[9:0]};
      apb(1'b0, OFF_RESULT_LOW, 8'h00);
      `CHK(rd, e[7:0])
      apb(1'b0, OFF_RESULT_HIGH, 8'h00);
      `CHK(rd, e[15:8])
    end
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, OFF_CTRL_B + 12'(i * 4), 8'h00);
      `CHK(rd, 8'h00)
    end
    apb(1'b0, 12'h020, 8'h00);
    `CHK(err, 1'b1)
    gie <= 1'b1;
    // Converter stays enabled until the final disable write, as the settling time asks
    for (int p = 0; p < 8; p++) begin
      val <= 10'($random(seed));
      apb(1'b1, OFF_CTRL_STATUS, 8'hD8 | 8'(p));
      // Tick counting starts at the start edge, so no early tick is missed
      fork
        begin
          apb(1'b0, OFF_CTRL_STATUS, 8'h00);
          `CHK(rd, 8'hC8 | 8'(p))
          `CHK(rd[4], 1'b0)
        end
        run(p == 0 ? 25 : 13, p < 2 ? 2 : 1 << p, 1'b0);
      join
      apb(1'b0, OFF_CTRL_STATUS, 8'h00);
      `CHK(rd, 8'h98 | 8'(p))
      `CHK(irq, 1'b1)
      res_chk;
    end
    gie <= 1'b0;
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    apb(1'b0, OFF_RESULT_LOW, 8'h00);
    lk = 1;
    val <= ~val;
    apb(1'b1, OFF_CTRL_STATUS, 8'hC0);
    run(13, 2, 1'b0);
    apb(1'b0, OFF_RESULT_HIGH, 8'h00);
    `CHK(rd, 8'(res >> 2))
    lk = 0;
    res_chk;
    ack <= 1'b1;
    @(posedge mclk);
    ack <= 1'b0;
    apb(1'b0, OFF_CTRL_STATUS, 8'h00);
    `CHK(rd, 8'h80)
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, OFF_INPUT_SELECT, 8'(c));
      @(posedge mclk);
      `CHK(df, 1'(c >= 4 && c <= 11))
      `CHK(gn, 1'(c >= 4 && c <= 11 && c % 2 == 1))
    end
    apb(1'b1, OFF_CTRL_STATUS, 8'hC0);
    fork
      begin
        apb(1'b1, OFF_INPUT_SELECT, 8'h05);
        `CHK(ch, 4'hF)
      end
      run(13, 2, 1'b0);
    join
    @(posedge mclk);
    `CHK(ch, 4'h5)
    s = 1 + ($unsigned($random(seed)) % 6);
    apb(1'b1, OFF_CTRL_B, 8'(s));
    apb(1'b1, OFF_CTRL_STATUS, 8'hA0);
    trig[s] <= 1'b1;
    run(13, 2, 1'b0);
    trig <= '0;
    apb(1'b1, OFF_CTRL_B, 8'h00);
    apb(1'b1, OFF_CTRL_STATUS, 8'hE0);
    run(13, 2, 1'b1);
    run(13, 2, 1'b1);
    // Disable lands a few cycles into the third free-running conversion
    apb(1'b1, OFF_CTRL_STATUS, 8'h00);
    repeat (2) @(posedge mclk);
    `CHK(smp, 1'b0)
    `CHK(pwr, 1'b0)
    apb(1'b0, OFF_CTRL_STATUS, 8'h00);
    `CHK(rd[6], 1'b0)
    conclude;
  end
endmodule
